// ===== design/u9b_uart_defines.vh
// constants for the 9-bit capable serial port: register addresses, bit fields, counts
`ifndef U9B_UART_DEFINES_VH
`define U9B_UART_DEFINES_VH
`define U9B_ADDR_PROGRAM_CONTROL 8'h87
`define U9B_ADDR_SERIAL_CONTROL 8'h98
`define U9B_ADDR_SERIAL_BUFFER 8'h99
`define U9B_ADDR_BAUD_FRACTION 8'h9D
`define U9B_ADDR_BAUD_TIMER_CONTROL 8'h9E
`define U9B_ADDR_TIMER2_CONTROL 8'hC8
`define U9B_RST_BYTE 8'h00
// program_control
`define U9B_PC_BAUD_DOUBLE 7
// serial_control
`define U9B_SC_MODE_HI 7
`define U9B_SC_MODE_LO 6
`define U9B_SC_MULTIPROC 5
`define U9B_SC_RX_ENABLE 4
`define U9B_SC_TX_NINTH 3
`define U9B_SC_RX_NINTH 2
`define U9B_SC_TX_DONE 1
`define U9B_SC_RX_DONE 0
// timer2_control
`define U9B_T2_RX_CLK_SEL 5
`define U9B_T2_TX_CLK_SEL 4
`define U9B_T2_RUN 2
// baud_timer_control
`define U9B_BT_OVERWRITE 7
`define U9B_BT_FRAME_ERR 6
`define U9B_BT_BREAK_ERR 5
`define U9B_BT_EXT_DIV 4:3
`define U9B_BT_INT_SHIFT 2:0
`define U9B_BF_FRACTION 5:0
// mode codes {mode_sel_hi, mode_sel_lo}
`define U9B_MODE_SHIFT 2'b00
`define U9B_MODE_8BIT 2'b01
`define U9B_MODE_9BIT_FIXED 2'b10
// mode 0 divider: 12 core clocks per bit, clock high from count 6
`define U9B_M0_LAST 4'hB
`define U9B_M0_HALF 4'h6
// 16x oversampling
`define U9B_OS_LAST 4'hF
`define U9B_OS_MID 4'h7
// last bit index of a frame
`define U9B_M0_LAST_BIT 4'h7
`define U9B_M1_LAST_BIT 4'h9
`define U9B_M2_LAST_BIT 4'hA
// line low for 9 bit times at 16 ticks each
`define U9B_BREAK_TICKS 8'h90
// uart timer: base step 64 per core clock
`define U9B_UT_BASE 17'h00040
`define U9B_T2_TOP 16'hFFFF
`endif

// ===== design/u9b_uart.v
// serial port with shift, 8-bit and 9-bit modes, baud sources and extended error flags
// How it works
// - 9-bit send: data LSB first, then ninth bit
// - sending starts at next baud tick
// - tx done flag set as stop bit starts
// - extended off: accept only if rx flag clear
// - multiprocessor 9-bit: need ninth bit set
// - accept: latch byte, ninth bit, set flag
// - both mode bits set select mode 3
// - mode 3 frames like mode 2
// - buffer write starts transmission in every mode
// - mode 0 receive needs flag clear, enable
// - async receive starts on start bit if enabled
// - mode 0 bit rate is clock/12
// - mode 2 rate clock/32 or clock/16
// - timer 1 rate: overflow times 2^double/32
// - timer 2 select bits give clock/(32*(65536-reload))
// - timer 2 counts every two clocks, 16 overflows/bit
// - transmit and receive timer 2 selects independent, uart timer select shared
// - uart timer shift is integer plus extended field
// - uart timer rate scaled by 1+fraction/64
// - frame error flag when stop bit missing
// - break flag when line low for 9 bit times, extended on only
// - 8-bit multiprocessor: need stop, store it
// - overwrite flag when unread byte replaced
// - mode 0 is synchronous shift, clock on txd
// - mode 1 is 10-bit async frame
// - mode 2 is 11-bit frame, fixed rate
// - extended on: async receive even with rx flag set, overwrite cleared by read
`timescale 1ns/1ns
`include "u9b_uart_defines.vh"
module u9b_uart (
    input wire sys_clk_i,
    input wire rst_n_i,
    input wire [7:0] sfr_addr_i,
    input wire sfr_wr_i,
    input wire sfr_rd_i,
    input wire [7:0] sfr_wdata_i,
    output reg [7:0] sfr_rdata_o,
    input wire extended_uart_en_i,
    input wire uart_timer_sel_i,
    input wire t1_ovf_i,
    input wire [7:0] t2_reload_high_i,
    input wire [7:0] t2_reload_low_i,
    input wire rxd_i,
    output reg rxd_o,
    output reg rxd_oe_o,
    output reg txd_o
);
    localparam TX_IDLE = 3'b001;
    localparam TX_WAIT = 3'b010;
    localparam TX_SEND = 3'b100;
    localparam RX_IDLE = 3'b001;
    localparam RX_ASYNC = 3'b010;
    localparam RX_SHIFT = 3'b100;

    reg [7:0] program_control;
    reg [7:0] serial_control;
    reg [7:0] timer2_control;
    reg [7:0] baud_fraction;
    reg [4:0] baud_div;
    reg [7:0] rx_buf;
    reg overwrite_err_flag;
    reg frame_err_flag;
    reg break_err_flag;

    // register strobes
    wire wr_pc = sfr_wr_i && (sfr_addr_i == `U9B_ADDR_PROGRAM_CONTROL);
    wire wr_sc = sfr_wr_i && (sfr_addr_i == `U9B_ADDR_SERIAL_CONTROL);
    wire wr_sb = sfr_wr_i && (sfr_addr_i == `U9B_ADDR_SERIAL_BUFFER);
    wire rd_sb = sfr_rd_i && (sfr_addr_i == `U9B_ADDR_SERIAL_BUFFER);
    wire wr_bf = sfr_wr_i && (sfr_addr_i == `U9B_ADDR_BAUD_FRACTION);
    wire wr_bt = sfr_wr_i && (sfr_addr_i == `U9B_ADDR_BAUD_TIMER_CONTROL);
    wire wr_t2 = sfr_wr_i && (sfr_addr_i == `U9B_ADDR_TIMER2_CONTROL);

    // mode decode, mode 3 shares everything with mode 2 but the rate source
    wire [1:0] mode = {serial_control[`U9B_SC_MODE_HI], serial_control[`U9B_SC_MODE_LO]};
    wire mode0 = (mode == `U9B_MODE_SHIFT);
    wire mode1 = (mode == `U9B_MODE_8BIT);
    wire baud_double = program_control[`U9B_PC_BAUD_DOUBLE];
    wire rx_done = serial_control[`U9B_SC_RX_DONE];

    // pick a 16x tick: mode 2 fixed, else timer 2, uart timer or timer 1
    function pick_tick;
        input [1:0] md;
        input t2_sel;
        input ut_sel;
        input t2_t;
        input ut_t;
        input t1_t;
        input m2_t;
        begin
            if (md == `U9B_MODE_9BIT_FIXED) begin
                pick_tick = m2_t;
            end else if (t2_sel) begin
                pick_tick = t2_t;
            end else if (ut_sel) begin
                pick_tick = ut_t;
            end else begin
                pick_tick = t1_t;
            end
        end
    endfunction

    // timer 2 baud generator: counts every second clock, reloads on overflow
    reg t2_phase;
    reg [15:0] t2_count;
    reg t2_ovf;
    wire t2_run = timer2_control[`U9B_T2_RUN] &&
        (timer2_control[`U9B_T2_TX_CLK_SEL] || timer2_control[`U9B_T2_RX_CLK_SEL]);
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            t2_phase <= 1'b0;
            t2_count <= 16'h0000;
            t2_ovf <= 1'b0;
        end else begin
            t2_ovf <= 1'b0;
            if (t2_run) begin
                t2_phase <= ~t2_phase;
                if (t2_phase) begin
                    if (t2_count == `U9B_T2_TOP) begin
                        t2_count <= {t2_reload_high_i, t2_reload_low_i};
                        t2_ovf <= 1'b1;
                    end else begin
                        t2_count <= t2_count + 16'h0001;
                    end
                end
            end else begin
                t2_phase <= 1'b0;
            end
        end
    end

    // uart timer: phase accumulator, step 64+fraction against 64 shifted left
    reg [16:0] ut_acc;
    reg ut_tick;
    wire [3:0] ut_shift = {2'b00, baud_div[4:3]} + {1'b0, baud_div[2:0]};
    wire [16:0] ut_limit = `U9B_UT_BASE << ut_shift;
    wire [16:0] ut_sum = ut_acc + {10'h000, 1'b1, baud_fraction[`U9B_BF_FRACTION]};
    // timer 1 halved unless doubled, mode 2 tick every clock or every other
    reg t1_half;
    reg m2_half;
    reg [3:0] m0_cnt;
    wire t1_tick = t1_ovf_i && (baud_double || t1_half);
    wire m2_tick = baud_double || m2_half;
    wire m0_tick = (m0_cnt == `U9B_M0_LAST);
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ut_acc <= 17'h00000;
            ut_tick <= 1'b0;
            t1_half <= 1'b0;
            m2_half <= 1'b0;
            m0_cnt <= 4'h0;
        end else begin
            if (ut_sum >= ut_limit) begin
                ut_acc <= ut_sum - ut_limit;
                ut_tick <= 1'b1;
            end else begin
                ut_acc <= ut_sum;
                ut_tick <= 1'b0;
            end
            if (t1_ovf_i) begin
                t1_half <= ~t1_half;
            end
            m2_half <= ~m2_half;
            m0_cnt <= m0_tick ? 4'h0 : m0_cnt + 4'h1;
        end
    end

    // separate timer 2 select per direction, uart timer select and timer 1 shared
    wire tx_tick16 = pick_tick(mode, timer2_control[`U9B_T2_TX_CLK_SEL], uart_timer_sel_i,
        t2_ovf, ut_tick, t1_tick, m2_tick);
    wire rx_tick16 = pick_tick(mode, timer2_control[`U9B_T2_RX_CLK_SEL], uart_timer_sel_i,
        t2_ovf, ut_tick, t1_tick, m2_tick);

    // receive pin synchroniser; edge detect looks only at the later stages
    reg rxd_meta;
    reg rxd_sync;
    reg rxd_prev;
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rxd_meta <= 1'b1;
            rxd_sync <= 1'b1;
            rxd_prev <= 1'b1;
        end else begin
            rxd_meta <= rxd_i;
            rxd_sync <= rxd_meta;
            rxd_prev <= rxd_sync;
        end
    end

    // transmit
    reg [2:0] tx_state;
    reg [10:0] tx_shift;
    reg [3:0] tx_cnt;
    reg [3:0] tx_os;
    reg [2:0] next_tx_state;
    reg [10:0] next_tx_shift;
    reg [3:0] next_tx_cnt;
    reg tx_set_done;
    wire tx_bit = mode0 ? m0_tick : (tx_tick16 && (tx_os == `U9B_OS_LAST));
    wire [3:0] tx_last = mode0 ? `U9B_M0_LAST_BIT : (mode1 ? `U9B_M1_LAST_BIT : `U9B_M2_LAST_BIT);
    reg [2:0] rx_state;

    always @* begin
        next_tx_state = tx_state;
        next_tx_shift = tx_shift;
        next_tx_cnt = tx_cnt;
        tx_set_done = 1'b0;
        case (tx_state)
            TX_IDLE: begin
                next_tx_state = TX_IDLE;
            end
            TX_WAIT: begin
                if (tx_bit) begin
                    next_tx_state = TX_SEND;
                end
            end
            TX_SEND: begin
                if (tx_bit) begin
                    if (tx_cnt == tx_last) begin
                        next_tx_state = TX_IDLE;
                        tx_set_done = mode0;
                    end else begin
                        next_tx_shift = {1'b1, tx_shift[10:1]};
                        next_tx_cnt = tx_cnt + 4'h1;
                        tx_set_done = !mode0 && (next_tx_cnt == tx_last);
                    end
                end
            end
            default: begin
                next_tx_state = TX_IDLE;
            end
        endcase
        // a buffer write always restarts the frame
        if (wr_sb) begin
            next_tx_state = TX_WAIT;
            next_tx_cnt = 4'h0;
            if (mode0) begin
                next_tx_shift = {3'b111, sfr_wdata_i};
            end else if (mode1) begin
                next_tx_shift = {2'b11, sfr_wdata_i, 1'b0};
            end else begin
                next_tx_shift = {1'b1, serial_control[`U9B_SC_TX_NINTH], sfr_wdata_i, 1'b0};
            end
        end
    end

    // outputs registered from next state so line and done flag move together
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_state <= TX_IDLE;
            tx_shift <= 11'h7FF;
            tx_cnt <= 4'h0;
            tx_os <= 4'h0;
            txd_o <= 1'b1;
            rxd_o <= 1'b1;
            rxd_oe_o <= 1'b0;
        end else begin
            tx_state <= next_tx_state;
            tx_shift <= next_tx_shift;
            tx_cnt <= next_tx_cnt;
            if (tx_tick16) begin
                tx_os <= tx_os + 4'h1;
            end
            if (mode0) begin
                // shift clock low for the first half of each bit
                txd_o <= ((next_tx_state == TX_SEND) || (rx_state == RX_SHIFT)) ?
                    (m0_cnt >= `U9B_M0_HALF) : 1'b1;
                rxd_oe_o <= (next_tx_state == TX_SEND);
                rxd_o <= (next_tx_state == TX_SEND) ? next_tx_shift[0] : 1'b1;
            end else begin
                txd_o <= (next_tx_state == TX_SEND) ? next_tx_shift[0] : 1'b1;
                rxd_oe_o <= 1'b0;
                rxd_o <= 1'b1;
            end
        end
    end

    // receive
    reg [3:0] rx_os;
    reg [3:0] rx_cnt;
    reg [8:0] rx_shift;
    reg rx_accept;
    reg rx_stop_seen;
    reg rx_frame_end;
    reg rx_ninth;
    reg [7:0] rx_data;
    reg [7:0] brk_cnt;
    wire [3:0] rx_last = mode1 ? `U9B_M1_LAST_BIT : `U9B_M2_LAST_BIT;
    wire rx_sample = rx_tick16 && (rx_os == `U9B_OS_MID);
    // byte and ninth bit position depend on frame length
    wire [7:0] async_data = mode1 ? rx_shift[8:1] : rx_shift[7:0];
    wire async_ninth = mode1 ? rxd_sync : rx_shift[8];
    // acceptance test at the stop bit sample
    wire async_ok = (extended_uart_en_i || !rx_done) &&
        (!serial_control[`U9B_SC_MULTIPROC] || async_ninth);

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_state <= RX_IDLE;
            rx_os <= 4'h0;
            rx_cnt <= 4'h0;
            rx_shift <= 9'h000;
            rx_accept <= 1'b0;
            rx_frame_end <= 1'b0;
            rx_stop_seen <= 1'b1;
            rx_ninth <= 1'b0;
            rx_data <= 8'h00;
        end else begin
            rx_accept <= 1'b0;
            rx_frame_end <= 1'b0;
            if (rx_tick16) begin
                rx_os <= rx_os + 4'h1;
            end
            case (rx_state)
                RX_IDLE: begin
                    rx_cnt <= 4'h0;
                    if (mode0) begin
                        if (m0_tick && !rx_done && serial_control[`U9B_SC_RX_ENABLE]) begin
                            rx_state <= RX_SHIFT;
                        end
                    end else if (serial_control[`U9B_SC_RX_ENABLE] && rxd_prev && !rxd_sync) begin
                        rx_state <= RX_ASYNC;
                        rx_os <= 4'h0;
                    end
                end
                RX_ASYNC: begin
                    if (rx_sample) begin
                        if (rx_cnt == 4'h0) begin
                            // a start bit gone high by mid-bit was a glitch
                            rx_state <= rxd_sync ? RX_IDLE : RX_ASYNC;
                            rx_cnt <= 4'h1;
                        end else if (rx_cnt == rx_last) begin
                            rx_state <= RX_IDLE;
                            rx_frame_end <= 1'b1;
                            rx_stop_seen <= rxd_sync;
                            rx_accept <= async_ok;
                            rx_data <= async_data;
                            rx_ninth <= async_ninth;
                        end else begin
                            rx_shift <= {rxd_sync, rx_shift[8:1]};
                            rx_cnt <= rx_cnt + 4'h1;
                        end
                    end
                end
                RX_SHIFT: begin
                    // sample at the end of the high clock phase
                    if (m0_tick) begin
                        rx_shift <= {rxd_sync, rx_shift[8:1]};
                        rx_cnt <= rx_cnt + 4'h1;
                        if (rx_cnt == `U9B_M0_LAST_BIT) begin
                            rx_state <= RX_IDLE;
                            rx_accept <= 1'b1;
                            rx_data <= {rxd_sync, rx_shift[8:2]};
                            rx_ninth <= serial_control[`U9B_SC_RX_NINTH];
                        end
                    end
                end
                default: begin
                    rx_state <= RX_IDLE;
                end
            endcase
            // clearing rx enable mid-frame drops the frame
            if (!serial_control[`U9B_SC_RX_ENABLE]) begin
                rx_state <= RX_IDLE;
            end
        end
    end

    // break counter in 16x ticks while the line stays low
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            brk_cnt <= 8'h00;
        end else if (rxd_sync || mode0) begin
            brk_cnt <= 8'h00;
        end else if (rx_tick16 && (brk_cnt != `U9B_BREAK_TICKS)) begin
            brk_cnt <= brk_cnt + 8'h01;
        end
    end

    // software registers; hardware set beats a same-cycle software clear
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            program_control <= `U9B_RST_BYTE;
            serial_control <= `U9B_RST_BYTE;
            timer2_control <= `U9B_RST_BYTE;
            baud_fraction <= `U9B_RST_BYTE;
            baud_div <= 5'h00;
            rx_buf <= `U9B_RST_BYTE;
            overwrite_err_flag <= 1'b0;
            frame_err_flag <= 1'b0;
            break_err_flag <= 1'b0;
        end else begin
            if (wr_pc) begin
                program_control <= sfr_wdata_i;
            end
            if (wr_t2) begin
                timer2_control <= sfr_wdata_i;
            end
            if (wr_bf) begin
                baud_fraction <= sfr_wdata_i;
            end
            if (wr_sc) begin
                serial_control <= sfr_wdata_i;
            end
            if (tx_set_done) begin
                serial_control[`U9B_SC_TX_DONE] <= 1'b1;
            end
            if (rx_accept) begin
                rx_buf <= rx_data;
                serial_control[`U9B_SC_RX_NINTH] <= rx_ninth;
                serial_control[`U9B_SC_RX_DONE] <= 1'b1;
            end
            // error flags: writing 0 clears, writing 1 leaves them alone
            if (wr_bt) begin
                baud_div <= {sfr_wdata_i[`U9B_BT_EXT_DIV], sfr_wdata_i[`U9B_BT_INT_SHIFT]};
                overwrite_err_flag <= overwrite_err_flag & sfr_wdata_i[`U9B_BT_OVERWRITE];
                frame_err_flag <= frame_err_flag & sfr_wdata_i[`U9B_BT_FRAME_ERR];
                break_err_flag <= break_err_flag & sfr_wdata_i[`U9B_BT_BREAK_ERR];
            end
            if (rd_sb) begin
                overwrite_err_flag <= 1'b0;
            end
            if (rx_accept && extended_uart_en_i && rx_done) begin
                overwrite_err_flag <= 1'b1;
            end
            if (rx_frame_end && !rx_stop_seen) begin
                frame_err_flag <= 1'b1;
            end
            if (extended_uart_en_i && (brk_cnt == `U9B_BREAK_TICKS)) begin
                break_err_flag <= 1'b1;
            end
        end
    end

    // read data registered; unmapped addresses read zero
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sfr_rdata_o <= 8'h00;
        end else if (!sfr_rd_i) begin
            sfr_rdata_o <= 8'h00;
        end else begin
            case (sfr_addr_i)
                `U9B_ADDR_PROGRAM_CONTROL: sfr_rdata_o <= program_control;
                `U9B_ADDR_SERIAL_CONTROL: sfr_rdata_o <= serial_control;
                `U9B_ADDR_SERIAL_BUFFER: sfr_rdata_o <= rx_buf;
                `U9B_ADDR_BAUD_FRACTION: sfr_rdata_o <= baud_fraction;
                `U9B_ADDR_BAUD_TIMER_CONTROL: sfr_rdata_o <= {overwrite_err_flag, frame_err_flag,
                    break_err_flag, baud_div};
                `U9B_ADDR_TIMER2_CONTROL: sfr_rdata_o <= timer2_control;
                default: sfr_rdata_o <= 8'h00;
            endcase
        end
    end
endmodule

// ===== verification/u9b_uart_assertions.sv
// checker on the serial port pins and register read port
`timescale 1ns/1ns
module u9b_uart_checker (
    input wire sys_clk_i,
    input wire rst_n_i,
    input wire [7:0] sfr_addr_i,
    input wire sfr_wr_i,
    input wire sfr_rd_i,
    input wire [7:0] sfr_wdata_i,
    input wire [7:0] sfr_rdata_o,
    input wire rxd_o,
    input wire rxd_oe_o,
    input wire txd_o
);
    reg [1:0] mode_q;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    // shadow of the mode bits so line checks know the framing
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_q <= 2'b00;
        end else if (sfr_wr_i && sfr_addr_i == 8'h98) begin
            mode_q <= sfr_wdata_i[7:6];
        end
    end
    sequence s_buf_wr;
        sfr_wr_i && sfr_addr_i == 8'h99 && txd_o;
    endsequence
    sequence s_m0_clk;
        !txd_o [*6] ##1 txd_o;
    endsequence
    property p_tx_wait;
        s_buf_wr |=> txd_o;
    endproperty
    property p_rd_mode;
        sfr_rd_i && sfr_addr_i == 8'h98 |=> sfr_rdata_o[7:6] == mode_q;
    endproperty
    property p_oe_mode0;
        rxd_oe_o |-> mode_q == 2'b00;
    endproperty
    property p_rxd_idle;
        !rxd_oe_o |-> rxd_o;
    endproperty
    property p_start_len;
        $fell(txd_o) && mode_q != 2'b00 |-> !txd_o [*8];
    endproperty
    property p_high_len;
        $rose(txd_o) && mode_q != 2'b00 |-> txd_o [*8];
    endproperty
    property p_m0_clk;
        $fell(txd_o) && mode_q == 2'b00 |-> s_m0_clk;
    endproperty
    property p_unmapped;
        sfr_rd_i && !(sfr_addr_i inside {8'h87, 8'h98, 8'h99, 8'h9D, 8'h9E, 8'hC8}) |=> sfr_rdata_o == 8'h00;
    endproperty
    property p_rd_idle;
        !sfr_rd_i |=> sfr_rdata_o == 8'h00;
    endproperty
    property p_rst;
        $rose(rst_n_i) |-> txd_o && rxd_o && !rxd_oe_o;
    endproperty
    a_tx_wait: assert property (p_tx_wait) else $error("txd moved right after buffer write");
    a_rd_mode: assert property (p_rd_mode) else $error("mode bits read wrong");
    a_oe_mode0: assert property (p_oe_mode0) else $error("data pin driven outside mode 0");
    a_rxd_idle: assert property (p_rxd_idle) else $error("data out not high when released");
    a_start_len: assert property (p_start_len) else $error("async low bit too short");
    a_high_len: assert property (p_high_len) else $error("async high bit too short");
    a_m0_clk: assert property (p_m0_clk) else $error("shift clock low phase not 6 cycles");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero without read");
    a_rst: assert property (p_rst) else $error("pins not idle after reset");
endmodule
bind u9b_uart u9b_uart_checker u_chk (.sys_clk_i, .rst_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i,
    .sfr_rdata_o, .rxd_o, .rxd_oe_o, .txd_o);

// ===== verification/u9b_remote_node.sv
// remote serial node: drives the receive line, samples the transmit line
`timescale 1ns/1ns
module u9b_remote_node (
    input wire clk_i,
    input wire line_i,
    output reg line_o
);
    initial line_o = 1'b1;
    // start bit then nb bits lsb first; line rests high after, as with a pull-up
    task automatic send(input logic [9:0] bits, input int nb, input int per);
        int i;
        for (i = 0; i <= nb; i++) begin
            line_o = (i == 0) ? 1'b0 : bits[i - 1];
            repeat (per) @(posedge clk_i);
            #1;
        end
        line_o = 1'b1;
    endtask
    // sample mid-bit after the falling start edge
    task automatic recv(input int nb, input int per, output logic [9:0] bits);
        int i;
        bits = '0;
        @(negedge line_i);
        repeat (per / 2) @(posedge clk_i);
        for (i = 0; i < nb; i++) begin
            repeat (per) @(posedge clk_i);
            bits[i] = line_i;
        end
    endtask
endmodule

// ===== verification/u9b_uart_tb_top.sv
// top bench: register, transmit, receive and error scenarios
`timescale 1ns/1ns
module u9b_uart_tb_top;
    reg sys_clk = 1'b0;
    reg rst_n = 1'b0;
    reg [7:0] addr = 8'h00;
    reg wr_s = 1'b0;
    reg rd_s = 1'b0;
    reg [7:0] wdata = 8'h00;
    reg ext_en = 1'b0;
    reg ut_sel = 1'b0;
    reg t1_ovf = 1'b0;
    wire [7:0] rdata;
    wire rxd_o, rxd_oe, txd, node_line;
    wire rxd_pin = rxd_oe ? rxd_o : node_line;
    int fails = 0;
    int checks_done = 0;
    logic [9:0] f;
    always #5 sys_clk = ~sys_clk;
    // overflow pulse every second clock stands in for timer 1
    always @(posedge sys_clk) t1_ovf <= #1 ~t1_ovf;
    u9b_uart u_dut (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .sfr_addr_i(addr), .sfr_wr_i(wr_s), .sfr_rd_i(rd_s),
        .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .extended_uart_en_i(ext_en), .uart_timer_sel_i(ut_sel),
        .t1_ovf_i(t1_ovf), .t2_reload_high_i(8'hFF), .t2_reload_low_i(8'hFF), .rxd_i(rxd_pin),
        .rxd_o(rxd_o), .rxd_oe_o(rxd_oe), .txd_o(txd));
    u9b_remote_node u_node (.clk_i(sys_clk), .line_i(txd), .line_o(node_line));
    task chk(input string n, input logic [9:0] e, input logic [9:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        @(posedge sys_clk) #1;
        addr = a;
        wdata = d;
        wr_s = 1'b1;
        @(posedge sys_clk) #1;
        wr_s = 1'b0;
    endtask
    task rdc(input string n, input [7:0] a, input [7:0] m, input [7:0] e);
        @(posedge sys_clk) #1;
        addr = a;
        rd_s = 1'b1;
        @(posedge sys_clk) #1;
        rd_s = 1'b0;
        chk(n, {2'b00, e}, {2'b00, rdata & m});
    endtask
    task t_regs;
        logic [7:0] am [7];
        int k;
        am = '{8'h87, 8'h98, 8'h99, 8'h9D, 8'h9E, 8'hC8, 8'h9A};
        for (k = 0; k < 7; k++) rdc("reset value", am[k], 8'hFF, 8'h00);
        wr(8'h9D, 8'hFF);
        rdc("fraction rw", 8'h9D, 8'hFF, 8'hFF);
        wr(8'h9D, 8'h00);
    endtask
    // one frame out of txd, sampled bit by bit by the remote node, checked as a whole
    task tx(input [7:0] ctl, input [7:0] bt, input sel, input [7:0] d, input int nb, input int per,
            input logic [9:0] e);
        ut_sel = sel;
        wr(8'h9E, bt);
        wr(8'h98, ctl);
        fork
            u_node.recv(nb, per, f);
            wr(8'h99, d);
        join
        chk("tx frame", e, f);
        rdc("tx done", 8'h98, 8'h02, 8'h02);
        // let the stop bit run out before the next mode change
        repeat (per) @(posedge sys_clk);
        #1;
    endtask
    task t_m0;
        time t0;
        int i;
        logic [7:0] b;
        wr(8'h98, 8'h00);
        wr(8'h99, 8'h96);
        for (i = 0; i < 8; i++) begin
            @(posedge txd);
            if (i == 1) t0 = $time;
            if (i == 2) chk("m0 period", 10'd120, 10'($time - t0));
            @(negedge sys_clk);
            b[i] = rxd_o;
            chk("m0 oe", 10'h001, {9'h000, rxd_oe});
        end
        chk("m0 data", 10'h096, {2'b00, b});
        repeat (12) @(posedge sys_clk);
        #1;
        rdc("m0 done", 8'h98, 8'h02, 8'h02);
    endtask
    // mode 0 receive: node puts a bit on the data pin at each falling shift clock
    task t_m0_rx;
        int i;
        wr(8'h98, 8'h10);
        for (i = 0; i < 8; i++) begin
            @(negedge txd) #1;
            u_node.line_o = i[0] ^ i[1];
        end
        repeat (24) @(posedge sys_clk);
        #1;
        u_node.line_o = 1'b1;
        rdc("m0 rx byte", 8'h99, 8'hFF, 8'h66);
    endtask
    task rx(input logic [9:0] b);
        u_node.send(b, 10, 16);
        repeat (20) @(posedge sys_clk);
        #1;
    endtask
    task t_rx;
        wr(8'h98, 8'h90);
        rx(10'h35A);
        rdc("rx byte", 8'h99, 8'hFF, 8'h5A);
        rdc("rx ctl", 8'h98, 8'hFF, 8'h95);
        rx(10'h233);
        rdc("kept byte", 8'h99, 8'hFF, 8'h5A);
        wr(8'h98, 8'hB0);
        rx(10'h244);
        rdc("mp drop", 8'h98, 8'hFF, 8'hB0);
        rx(10'h366);
        rdc("mp take", 8'h99, 8'hFF, 8'h66);
        wr(8'h98, 8'h90);
        ext_en = 1'b1;
        rx(10'h311);
        rx(10'h322);
        rdc("overwrite", 8'h9E, 8'h80, 8'h80);
        rdc("ext byte", 8'h99, 8'hFF, 8'h22);
        rdc("ow clear", 8'h9E, 8'h80, 8'h00);
        rx(10'h155);
        rdc("frame err", 8'h9E, 8'h40, 8'h40);
        wr(8'h98, 8'h80);
        rx(10'h377);
        rdc("rx off", 8'h99, 8'hFF, 8'h55);
        wr(8'h98, 8'h90);
        rx(10'h000);
        rdc("break", 8'h9E, 8'h20, 8'h20);
    endtask
    task end_sim;
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        t_regs;
        wr(8'h87, 8'h80);
        tx(8'h88, 8'h00, 1'b0, 8'hA5, 10, 16, 10'h3A5);
        tx(8'hC0, 8'h08, 1'b1, 8'h3C, 10, 32, 10'h23C);
        tx(8'h40, 8'h00, 1'b0, 8'hC3, 9, 32, 10'h1C3);
        wr(8'h87, 8'h00);
        tx(8'h80, 8'h00, 1'b0, 8'h81, 10, 32, 10'h281);
        wr(8'h87, 8'h80);
        t_m0;
        t_m0_rx;
        t_rx;
        end_sim;
    end
    // hang guard, about six times the expected run
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        end_sim;
    end
endmodule
